// ==== core/rsc_top.sv ====
// Reset cause recording, reset source enables and supply monitor control
//
// Functional notes
// - Bit 6 reads one after a flash error reset.
// - Bit 5 reads one after a comparator reset, else zero.
// - Writing one to bit 5 enables active-low comparator as reset source.
// - Writing one to bit 4 forces a system reset at once.
// - Bit 4 reads one after a software forced reset.
// - Bit 3 reads one after a watchdog overflow reset.
// - Bit 2 reads one after a missing-clock timeout reset.
// - Writing one to bit 2 enables clock loss detector, which then resets.
// - Bit 1 reads one after power-on or supply monitor reset.
// - Writing one to bit 1 selects supply monitor as reset source.
// - Bit 0 reads one after an external pin reset.
// - Reads return reset cause; writes only set source enables.
// - Other cause flags are indeterminate while the supply flag reads one.
// - Selecting an unstable or disabled monitor may reset; enable it first.
// - Supply control bit 7 switches the monitor off or on.
// - Enabled monitor resets only when also selected as reset source.
// - Supply control bit 6 shows live monitor output, one above threshold.
// - Any non power-on, non supply reset clears the supply flag.
// - Device resets keep monitor enable and selection unchanged.
// - Power-on leaves monitor enabled and selected as reset source.
`timescale 1ns/1ps
module rsc_top (
	// Clock and resets
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       por_n,
	// Special-function-register access
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Reset events from same-clock logic
	input  wire logic       wdt_overflow,
	input  wire logic       flash_fault,
	// Asynchronous inputs from pins and analog circuits
	input  wire logic       ext_rst_pin_n,
	input  wire logic       comp_out_n,
	input  wire logic       clock_missing,
	input  wire logic       supply_above,
	// Controls to analog circuits and reset generator
	output logic            supply_monitor_enable,
	output logic            clock_loss_detector_en,
	output logic            comparator_reset_en,
	output logic            sys_reset_req
);

	// Address match, used by both the read and write paths
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
		addr_hit = (a == r);
	endfunction

	logic [1:0]          rst_pipe_reg;
	logic [1:0]          por_pipe_reg;
	wire                 dev_rst_n;
	wire                 por_rst_n;
	logic [3:0]          async_in;
	logic [3:0]          sync_out;
	wire                 pin_n_s;
	wire                 comp_n_s;
	wire                 missing_s;
	wire                 above_s;
	logic                run_d_reg;
	wire                 leave_reset;
	rsc_pkg::rsc_cause_s pend_reg;
	rsc_pkg::rsc_cause_s pend_next;
	rsc_pkg::rsc_cause_s cause_reg;
	rsc_pkg::rsc_cause_s new_ev;
	logic                comp_en_reg;
	logic                mcd_en_reg;
	logic                sup_en_reg;
	logic                sup_sel_reg;
	logic [7:0]          rdata_reg;
	logic [7:0]          rdata_next;
	logic                req_reg;
	wire                 sup_stable;
	wire                 wr_ok;
	wire                 wr_cause;
	wire                 wr_supply;
	wire                 sw_force;
	wire                 comp_trip;
	wire                 mcd_trip;
	wire                 sup_trip;

	// Release both resets through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_reg <= 2'h0;
		end else begin
			rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
		end
	end

	always_ff @(posedge core_clk or negedge por_n) begin
		if (!por_n) begin
			por_pipe_reg <= 2'h0;
		end else begin
			por_pipe_reg <= {por_pipe_reg[0], 1'b1};
		end
	end

	assign dev_rst_n = rst_pipe_reg[1];
	assign por_rst_n = por_pipe_reg[1];

	// Pin and analog inputs, synchronised in the power-on domain
	assign async_in = {ext_rst_pin_n, comp_out_n, clock_missing, supply_above};

	rsc_sync #(
		.W       (4),
		.RST_VAL (rsc_pkg::RSC_SYNC_RST)
	) u_sync (
		.clk     (core_clk),
		.rst_n   (por_rst_n),
		.d_async (async_in),
		.q_sync  (sync_out)
	);

	assign pin_n_s   = sync_out[3];
	assign comp_n_s  = sync_out[2];
	assign missing_s = sync_out[1];
	assign above_s   = sync_out[0];

	// Settling tracker gates the live supply level
	rsc_settle u_settle (
		.clk       (core_clk),
		.por_rst_n (por_rst_n),
		.enable    (sup_en_reg),
		.stable    (sup_stable)
	);

	// Write decode: cause address writes only the enables
	assign wr_ok     = sfr_wr && dev_rst_n;                                    // Ignored in reset
	assign wr_cause  = wr_ok && addr_hit(sfr_addr, rsc_pkg::RSC_ADDR_CAUSE);
	assign wr_supply = wr_ok && addr_hit(sfr_addr, rsc_pkg::RSC_ADDR_SUPPLY);
	assign sw_force  = wr_cause && sfr_wdata[rsc_pkg::RSC_BIT_SW];

	// Reset source trips
	assign comp_trip = comp_en_reg && !comp_n_s;
	assign mcd_trip  = mcd_en_reg && missing_s;
	assign sup_trip  = sup_sel_reg && !(sup_stable && above_s);

	// Events seen this cycle, one flag each
	assign new_ev = '{
		flash: flash_fault,
		comp:  comp_trip,
		sw:    sw_force,
		wdt:   wdt_overflow,
		clock_loss_detector:   mcd_trip,
		por:   sup_trip,
		pin:   !pin_n_s
	};

	// Reset exit: first cycle the released device reset is seen
	assign leave_reset = dev_rst_n && !run_d_reg;

	// Pending causes clear on capture; a new event in that cycle still wins
	assign pend_next = leave_reset ? new_ev : (pend_reg | new_ev);

	// Pending record survives device reset, so the cause is not lost
	always_ff @(posedge core_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			pend_reg  <= rsc_pkg::RSC_CAUSE_POR;
			run_d_reg <= 1'b0;
		end else begin
			pend_reg  <= pend_next;
			run_d_reg <= dev_rst_n;
		end
	end

	// Cause capture; a non-supply reset leaves the supply flag clear
	always_ff @(posedge core_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			cause_reg <= rsc_pkg::RSC_CAUSE_POR;
		end else if (leave_reset) begin
			cause_reg <= pend_reg;
		end
	end

	// Comparator and clock loss enables return to defaults on any device reset
	always_ff @(posedge core_clk or negedge dev_rst_n) begin
		if (!dev_rst_n) begin
			comp_en_reg <= rsc_pkg::RSC_COMP_EN_RST;
			mcd_en_reg  <= rsc_pkg::RSC_MCD_EN_RST;
		end else if (wr_cause) begin
			comp_en_reg <= sfr_wdata[rsc_pkg::RSC_BIT_COMP];
			mcd_en_reg  <= sfr_wdata[rsc_pkg::RSC_BIT_MCD];
		end
	end

	// Supply enable and selection change only on power-on or writes
	always_ff @(posedge core_clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			sup_en_reg  <= rsc_pkg::RSC_SUP_EN_POR;
			sup_sel_reg <= rsc_pkg::RSC_SUP_SEL_POR;
		end else begin
			if (wr_supply) begin
				sup_en_reg <= sfr_wdata[rsc_pkg::RSC_BIT_SUP_EN];
			end
			if (wr_cause) begin
				sup_sel_reg <= sfr_wdata[rsc_pkg::RSC_BIT_POR];
			end
		end
	end

	// Reset request, held until the device reset takes effect
	always_ff @(posedge core_clk or negedge dev_rst_n) begin
		if (!dev_rst_n) begin
			req_reg <= 1'b0;
		end else if (sw_force || comp_trip || mcd_trip || sup_trip) begin
			req_reg <= 1'b1;
		end
	end

	// Read mux: cause address always returns the captured cause
	always_comb begin
		rdata_next = 8'h00;
		if (addr_hit(sfr_addr, rsc_pkg::RSC_ADDR_CAUSE)) begin
			rdata_next = {1'b0, cause_reg};
		end else if (addr_hit(sfr_addr, rsc_pkg::RSC_ADDR_SUPPLY)) begin
			rdata_next[rsc_pkg::RSC_BIT_SUP_EN]    = sup_en_reg;
			rdata_next[rsc_pkg::RSC_BIT_SUP_LEVEL] = above_s;
		end
	end

	// Read data register, loaded on a read strobe
	always_ff @(posedge core_clk or negedge dev_rst_n) begin
		if (!dev_rst_n) begin
			rdata_reg <= rsc_pkg::RSC_RDATA_RST;
		end else if (sfr_rd) begin
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	assign sfr_rdata              = rdata_reg;
	assign supply_monitor_enable  = sup_en_reg;
	assign clock_loss_detector_en = mcd_en_reg;
	assign comparator_reset_en    = comp_en_reg;
	assign sys_reset_req          = req_reg;

endmodule // rsc_top

// ==== shared/rsc_pkg.sv ====
// Package: register map, field positions, reset values and timing for the reset cause block
package rsc_pkg;

	// Register addresses in the special-function-register space
	localparam logic [7:0] RSC_ADDR_CAUSE  = 8'hef;
	localparam logic [7:0] RSC_ADDR_SUPPLY = 8'hff;

	// Field positions of reset_cause_register
	localparam int RSC_BIT_FLASH = 6;
	localparam int RSC_BIT_COMP  = 5;
	localparam int RSC_BIT_SW    = 4;
	localparam int RSC_BIT_WDT   = 3;
	localparam int RSC_BIT_MCD   = 2;
	localparam int RSC_BIT_POR   = 1;
	localparam int RSC_BIT_PIN   = 0;

	// Field positions of supply_monitor_control
	localparam int RSC_BIT_SUP_EN    = 7;
	localparam int RSC_BIT_SUP_LEVEL = 6;

	// Values after reset
	localparam logic RSC_COMP_EN_RST = 1'b0;
	localparam logic RSC_MCD_EN_RST  = 1'b0;
	localparam logic RSC_SUP_EN_POR  = 1'b1;
	localparam logic RSC_SUP_SEL_POR = 1'b1;
	localparam logic [7:0] RSC_RDATA_RST = 8'h00;

	// Synchroniser reset levels: {pin_n, comp_n, missing_clk, supply_above}
	localparam logic [3:0] RSC_SYNC_RST = 4'hd;

	// Supply monitor settling time after enable
	localparam int RSC_CLK_PERIOD_NS = 8;
	localparam int RSC_SETTLE_NS     = 2000;
	localparam int RSC_SETTLE_CYCLES = (RSC_SETTLE_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
	localparam int RSC_SETTLE_W      = 16;

	// Reset cause flags, packed in register bit order 6..0
	typedef struct packed {
		logic flash;
		logic comp;
		logic sw;
		logic wdt;
		logic clock_loss_detector;
		logic por;
		logic pin;
	} rsc_cause_s;

	// Cause record after a power-on: only the supply flag is meaningful
	localparam rsc_cause_s RSC_CAUSE_POR = '{flash: 1'b0, comp: 1'b0, sw: 1'b0, wdt: 1'b0,
		clock_loss_detector: 1'b0, por: 1'b1, pin: 1'b0};

	// Supply settling states, Gray coded along off -> settling -> stable
	typedef enum logic [1:0] {
		RSC_SUP_OFF      = 2'b00,
		RSC_SUP_SETTLING = 2'b01,
		RSC_SUP_STABLE   = 2'b11
	} rsc_sup_state_e;

endpackage

// ==== core/rsc_sync.sv ====
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
module rsc_sync #(
	parameter int         W       = 4,
	parameter logic [3:0] RST_VAL = 4'h0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// One stage pair per bit; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg[i] <= RST_VAL[i];
					sync_reg[i] <= RST_VAL[i];
				end else begin
					meta_reg[i] <= d_async[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	assign q_sync = sync_reg;

endmodule // rsc_sync

// ==== core/rsc_settle.sv ====
// Supply monitor settling tracker: stable straight after power-on, else only after a fixed wait past enable
`timescale 1ns/1ps
module rsc_settle (
	// Clock and power-on reset
	input  wire logic clk,
	input  wire logic por_rst_n,
	// Monitor control and state
	input  wire logic enable,
	output logic      stable
);

	rsc_pkg::rsc_sup_state_e         state_reg;
	rsc_pkg::rsc_sup_state_e         state_next;
	logic [rsc_pkg::RSC_SETTLE_W-1:0] cnt_reg;
	logic [rsc_pkg::RSC_SETTLE_W-1:0] cnt_next;
	wire                              cnt_done;

	localparam logic [rsc_pkg::RSC_SETTLE_W-1:0] LAST =
		rsc_pkg::RSC_SETTLE_W'(rsc_pkg::RSC_SETTLE_CYCLES - 1);

	assign cnt_done = (cnt_reg == LAST);

	// Next state; power-on already waited, so reset lands in stable
	always_comb begin
		state_next = state_reg;
		cnt_next   = '0;
		case (state_reg)
			rsc_pkg::RSC_SUP_OFF: begin
				if (enable) begin
					state_next = rsc_pkg::RSC_SUP_SETTLING;
				end
			end
			rsc_pkg::RSC_SUP_SETTLING: begin
				cnt_next = cnt_reg + 1'b1;
				if (!enable) begin
					state_next = rsc_pkg::RSC_SUP_OFF;
				end else if (cnt_done) begin
					state_next = rsc_pkg::RSC_SUP_STABLE;
				end
			end
			rsc_pkg::RSC_SUP_STABLE: begin
				if (!enable) begin
					state_next = rsc_pkg::RSC_SUP_OFF;
				end
			end
			default: begin
				state_next = rsc_pkg::RSC_SUP_OFF;
			end
		endcase
	end

	// State and counter flops, cleared only by power-on
	always_ff @(posedge clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			state_reg <= rsc_pkg::RSC_SUP_STABLE;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign stable = (state_reg == rsc_pkg::RSC_SUP_STABLE) && enable;

endmodule // rsc_settle

// ==== dv/rsc_chk.sv ====
// Port checker for the reset cause block
`timescale 1ns/1ps
module rsc_chk (
	// Clock and resets
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       por_n,
	// Register access
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// Events and controls
	input wire logic       comp_out_n,
	input wire logic       clock_missing,
	input wire logic       supply_monitor_enable,
	input wire logic       clock_loss_detector_en,
	input wire logic       comparator_reset_en,
	input wire logic       sys_reset_req
);
	logic [2:0] run_reg;
	// Access decode once the released reset has settled
	wire run  = run_reg == 3'h5;
	wire wr_c = run && sfr_wr && sfr_addr == rsc_pkg::RSC_ADDR_CAUSE;
	wire wr_s = run && sfr_wr && sfr_addr == rsc_pkg::RSC_ADDR_SUPPLY;
	wire rd_u = run && sfr_rd && sfr_addr != 8'hef && sfr_addr != 8'hff;
	// Cycles since device reset release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			run_reg <= 3'h0;
		else if (!run)
			run_reg <= run_reg + 3'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_sw_req; wr_c && sfr_wdata[4] |=> sys_reset_req; endproperty
	a_sw_req: assert property (p_sw_req) else $error("soft reset missing");
	property p_req_hold; sys_reset_req |=> sys_reset_req; endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	property p_comp_en; wr_c |=> comparator_reset_en == $past(sfr_wdata[5]); endproperty
	a_comp_en: assert property (p_comp_en) else $error("comp enable wrong");
	property p_mcd_en; wr_c |=> clock_loss_detector_en == $past(sfr_wdata[2]); endproperty
	a_mcd_en: assert property (p_mcd_en) else $error("clock enable wrong");
	property p_sup_en; wr_s |=> supply_monitor_enable == $past(sfr_wdata[7]); endproperty
	a_sup_en: assert property (p_sup_en) else $error("supply enable wrong");
	property p_comp_trip; run && comparator_reset_en && !comp_out_n |-> ##[1:5] sys_reset_req;
	endproperty
	a_comp_trip: assert property (p_comp_trip) else $error("comp trip lost");
	property p_mcd_trip; run && clock_loss_detector_en && clock_missing |-> ##[1:5] sys_reset_req;
	endproperty
	a_mcd_trip: assert property (p_mcd_trip) else $error("clock trip lost");
	property p_unmapped; rd_u |-> ##2 sfr_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_rst_clear; disable iff (!por_n)
		$past(!rst_n) && !rst_n |->
			!comparator_reset_en && !clock_loss_detector_en && !sys_reset_req;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("reset left enables");
	property p_rst_keep; disable iff (!por_n) !rst_n |-> $stable(supply_monitor_enable);
	endproperty
	a_rst_keep: assert property (p_rst_keep) else $error("enable changed");
	property p_por_sup; disable iff (1'b0) $past(!por_n) && !por_n |-> supply_monitor_enable;
	endproperty
	a_por_sup: assert property (p_por_sup) else $error("por enable off");
	// Main scenarios
	c_sw: cover property (wr_c && sfr_wdata[4]);
	c_comp: cover property (run && comparator_reset_en && !comp_out_n);
	c_unmapped: cover property (rd_u);
endmodule // rsc_chk
bind rsc_top rsc_chk rsc_chk_inst (.core_clk, .rst_n, .por_n, .sfr_addr, .sfr_wr, .sfr_rd,
	.sfr_wdata, .sfr_rdata, .comp_out_n, .clock_missing, .supply_monitor_enable,
	.clock_loss_detector_en, .comparator_reset_en, .sys_reset_req);

// ==== dv/tb.sv ====
// Self-checking bench for the reset cause block
`timescale 1ns/1ps
module tb;
	logic       core_clk, rst_n, por_n, sfr_wr, sfr_rd, wdt_overflow, flash_fault;
	logic       ext_rst_pin_n, comp_out_n, clock_missing, supply_above;
	logic       supply_monitor_enable, clock_loss_detector_en, comparator_reset_en;
	logic       sys_reset_req;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, exp_cause;
	int         fail_count, samples_checked;
	int         cycles = 0;
	wire  [7:0] en_bits = {6'h0, comparator_reset_en, clock_loss_detector_en};
	localparam logic [7:0] CA = rsc_pkg::RSC_ADDR_CAUSE;
	localparam logic [7:0] SA = rsc_pkg::RSC_ADDR_SUPPLY;
	// Cause after each source, and which sources request a reset
	localparam logic [55:0] EXP = 56'h10_08_40_01_20_04_02;
	localparam logic [6:0] REQ = 7'h71;

	rsc_top rsc_top_inst (.core_clk, .rst_n, .por_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .wdt_overflow, .flash_fault, .ext_rst_pin_n, .comp_out_n, .clock_missing,
		.supply_above, .supply_monitor_enable, .clock_loss_detector_en, .comparator_reset_en,
		.sys_reset_req);

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		tick(1);
		chk(sfr_rdata, exp, what);
	endtask
	task automatic do_reset(input logic por);
		rst_n = 1'b0;
		por_n = ~por;
		tick(20);
		rst_n = 1'b1;
		por_n = 1'b1;
		tick(6);
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		{sfr_wr, sfr_rd, wdt_overflow, flash_fault, clock_missing} = 5'h00;
		{ext_rst_pin_n, comp_out_n, supply_above} = 3'h7;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		fail_count = 0;
		samples_checked = 0;
		do_reset(1'b1);
		rd(CA, 8'h02, "por cause");
		rd(SA, 8'hc0, "por supply");
		rd(8'h80, 8'h00, "unmapped");
		$display("Test power-on done");
		exp_cause = 8'h02;
		for (int i = 0; i < 7; i++) begin
			case (i)
				0: wr(CA, 8'h12);
				1: wdt_overflow = 1'b1;
				2: flash_fault = 1'b1;
				3: ext_rst_pin_n = 1'b0;
				4: wr(CA, 8'h22);
				5: wr(CA, 8'h06);
				default: supply_above = 1'b0;
			endcase
			tick(1);
			{wdt_overflow, flash_fault, ext_rst_pin_n} = 3'h1;
			chk(en_bits, {6'h0, i == 4, i == 5}, "en");
			comp_out_n = i != 4;
			clock_missing = i == 5;
			tick(6);
			if (i == 6)
				rd(SA, 8'h80, "level low");
			chk({7'h0, sys_reset_req}, {7'h0, REQ[i]}, "request");
			rd(CA, exp_cause, "held cause");
			{comp_out_n, clock_missing, supply_above} = 3'h5;
			do_reset(1'b0);
			exp_cause = EXP[8*(6-i) +: 8];
			rd(CA, exp_cause, "cause");
			chk(en_bits, 8'h00, "en clear");
		end
		$display("Test sources done");
		wr(CA, 8'h00);
		wr(SA, 8'h00);
		chk({7'h0, supply_monitor_enable}, 8'h00, "sup off");
		tick(8);
		chk({7'h0, sys_reset_req}, 8'h00, "unselected");
		rd(SA, 8'h40, "sup read");
		wr(CA, 8'h02);
		tick(2);
		chk({7'h0, sys_reset_req}, 8'h01, "select off");
		do_reset(1'b0);
		chk({7'h0, sys_reset_req}, 8'h01, "select kept");
		rd(SA, 8'h40, "enable kept");
		do_reset(1'b1);
		rd(SA, 8'hc0, "por again");
		rd(CA, 8'h02, "por cause");
		// Enable, wait out settling, then select: no reset expected
		wr(CA, 8'h00);
		wr(SA, 8'h00);
		wr(SA, 8'h80);
		tick(rsc_pkg::RSC_SETTLE_CYCLES + 4);
		wr(CA, 8'h02);
		tick(4);
		chk({7'h0, sys_reset_req}, 8'h00, "settled select");
		rd(SA, 8'hc0, "sup back on");
		// Select right after enabling: not yet settled, so a reset follows
		wr(CA, 8'h00);
		wr(SA, 8'h00);
		wr(SA, 8'h80);
		wr(CA, 8'h02);
		tick(1);
		chk({7'h0, sys_reset_req}, 8'h01, "unsettled select");
		$display("Test supply done");
		test_done();
	end
endmodule // tb
